// >>> src/otc_pkg.sv
`default_nettype none
package otc_pkg;
	// Core clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_TIME_NS = 40000;
	localparam int PERIOD_TIME_NS = 400000;
	localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PERIOD_CYC_DFLT = PERIOD_TIME_NS / CLK_PERIOD_NS;
	localparam int PERIOD_W = 16;
	localparam int CONV_W = 12;
	// Register pointer values
	localparam logic [7:0] REG_TEMP = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h01;
	localparam logic [7:0] REG_LOWER = 8'h02;
	localparam logic [7:0] REG_UPPER = 8'h03;
	localparam logic [7:0] REG_CFG2 = 8'h05;
	// Configuration field positions
	localparam int CFG_SHUTDOWN_BIT = 0;
	localparam int CFG_LATCHED_BIT = 1;
	localparam int CFG_POLARITY_BIT = 2;
	localparam int CFG_FAULT_LOW_BIT = 3;
	localparam int CFG_FAULT_HIGH_BIT = 4;
	localparam int CFG2_PIN_MODE_BIT = 7;
	localparam logic [7:0] CFG2_MASK = 8'hC0;
	// Values after reset
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CFG2_RST = 8'h00;
	localparam logic [8:0] UPPER_RST = 9'h0A0;
	localparam logic [8:0] LOWER_RST = 9'h096;
	localparam logic [9:0] TEMP_RST = 10'h000;
	// Fault queue lengths per field code
	localparam logic [2:0] FAULT_N0 = 3'h1;
	localparam logic [2:0] FAULT_N1 = 3'h2;
	localparam logic [2:0] FAULT_N2 = 3'h4;
	localparam logic [2:0] FAULT_N3 = 3'h6;

	typedef enum logic [1:0] {
		op_ptr,
		op_wr,
		op_rd,
		op_end
	} otc_op_type;

	typedef enum logic [1:0] {
		sch_idle,
		sch_conv,
		sch_off
	} otc_sched_type;

	typedef struct packed {
		logic valid;
		otc_op_type op;
		logic [7:0] data;
	} otc_cmd_type;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} otc_resp_type;
endpackage
`default_nettype wire

// >>> src/otc_alarm_sched.sv
// Behaviour
// - Polarity bit selects alarm active level
// - Alarm pin only sinks, open drain
// - Latched mode holds alarm until read
// - After upper clear, wait for low
// - After lower clear, rearm for upper
// - Comparator mode: upper sets, lower releases
// - Shutdown write clears alarm at once
// - Fault queue of 1,2,4,6 readings
// - Non-fault reading resets fault counter
// - Power-on defaults for pointer and limits
// - Periodic conversion every 400 us
// - Conversion lasts 40 us, then idle
// - Temperature read during conversion aborts and restarts
// - Period rebased on restarted conversion
// - Temperature read between conversions starts one
// - Shutdown stops conversions, bus stays alive
// - Write in shutdown gives one conversion
// - Second config top bit powers down conversions, like shutdown
`timescale 1ns/10ps
`default_nettype none
module otc_alarm_sched #(
	parameter int PERIOD_CYCLES = otc_pkg::PERIOD_CYC_DFLT
) (
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_link_clock,
	input wire otc_pkg::otc_cmd_type i_bus_cmd,
	output logic o_bus_ready,
	output otc_pkg::otc_resp_type o_bus_resp,
	input wire logic [9:0] i_conv_code,
	output logic o_conv_run,
	output logic o_conv_powered,
	input wire logic i_alarm_in,
	output logic o_alarm_out,
	output logic o_alarm_oe_n,
	output logic o_alarm_line_low
);
	import otc_pkg::*;

	logic rst_s1_ff, rst_n_ff, lrst_s1_ff, lrst_n_ff;
	otc_cmd_type hold_ff;
	otc_resp_type resp_ff;
	logic req_tog_ff, ack_s1_ff, ack_s2_ff, ack_seen_ff;
	logic req_s1_ff, req_s2_ff, req_seen_ff, ack_tog_ff;
	logic [15:0] resp_hold_ff;
	logic [15:0] nxt_resp;
	logic new_cmd, is_wr, is_rd, end_evt;
	logic [7:0] ptr_ff, cfg_ff, cfg2_ff;
	logic [8:0] upper_ff, lower_ff;
	logic [9:0] temp_ff;
	logic byte_idx_ff, had_read_ff, had_temp_rd_ff, wake_pend_ff;
	logic restart_req, wake_req, latched_clear, sd_clear, off_req;
	otc_sched_type state_ff;
	logic [CONV_W-1:0] conv_cnt_ff;
	logic [PERIOD_W-1:0] period_cnt_ff;
	logic oneshot_ff, conv_done;
	logic alarm_ff, arm_low_ff, oe_n_ff, line_s1_ff, line_s2_ff;
	logic [2:0] fault_cnt_ff, fault_inc;
	logic hi_fault, lo_fault, watch_low, relevant, trip;

	function automatic logic [2:0] fault_need(input logic [1:0] code);
		case (code)
			2'h0: fault_need = FAULT_N0;
			2'h1: fault_need = FAULT_N1;
			2'h2: fault_need = FAULT_N2;
			default: fault_need = FAULT_N3;
		endcase
	endfunction

	// Reset release, one synchroniser per domain
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	always_ff @(posedge i_link_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lrst_s1_ff <= 1'b0;
			lrst_n_ff <= 1'b0;
		end
		else
		begin
			lrst_s1_ff <= 1'b1;
			lrst_n_ff <= lrst_s1_ff;
		end
	end

	// Link side: one command in flight, held stable until the core acks
	assign o_bus_ready = (ack_seen_ff == req_tog_ff);
	assign o_bus_resp = resp_ff;

	always_ff @(posedge i_link_clock or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			hold_ff <= '0;
			req_tog_ff <= 1'b0;
		end
		else if (i_bus_cmd.valid && o_bus_ready)
		begin
			hold_ff <= i_bus_cmd;
			req_tog_ff <= ~req_tog_ff;
		end
	end

	always_ff @(posedge i_link_clock or negedge lrst_n_ff)
	begin
		if (!lrst_n_ff)
		begin
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_seen_ff <= 1'b0;
			resp_ff <= '0;
		end
		else
		begin
			ack_s1_ff <= ack_tog_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_seen_ff <= ack_s2_ff;
			resp_ff.valid <= (ack_s2_ff != ack_seen_ff);
			if (ack_s2_ff != ack_seen_ff)
			begin
				resp_ff.data <= resp_hold_ff;
			end
		end
	end

	// Core side of the handshake; hold_ff is stable while the toggle is open
	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			req_s1_ff <= 1'b0;
			req_s2_ff <= 1'b0;
			req_seen_ff <= 1'b0;
			ack_tog_ff <= 1'b0;
			resp_hold_ff <= 16'h0000;
		end
		else
		begin
			req_s1_ff <= req_tog_ff;
			req_s2_ff <= req_s1_ff;
			req_seen_ff <= req_s2_ff;
			if (new_cmd)
			begin
				ack_tog_ff <= req_s2_ff;
				resp_hold_ff <= nxt_resp;
			end
		end
	end

	assign new_cmd = (req_s2_ff != req_seen_ff);
	assign is_wr = new_cmd && (hold_ff.op == op_wr);
	assign is_rd = new_cmd && (hold_ff.op == op_rd);
	assign end_evt = new_cmd && (hold_ff.op == op_end);
	assign off_req = cfg_ff[CFG_SHUTDOWN_BIT] || cfg2_ff[CFG2_PIN_MODE_BIT];
	assign restart_req = end_evt && had_temp_rd_ff && (state_ff != sch_off);
	assign wake_req = end_evt && wake_pend_ff && (state_ff == sch_off);
	assign latched_clear = end_evt && had_read_ff && cfg_ff[CFG_LATCHED_BIT];
	assign sd_clear = is_wr && (ptr_ff == REG_CFG) && hold_ff.data[CFG_SHUTDOWN_BIT];

	// Read data; the result register keeps the last completed conversion
	always_comb
	begin
		case (ptr_ff)
			REG_TEMP: nxt_resp = {temp_ff, 6'h00};
			REG_CFG: nxt_resp = {cfg_ff, 8'h00};
			REG_LOWER: nxt_resp = {lower_ff, 7'h00};
			REG_UPPER: nxt_resp = {upper_ff, 7'h00};
			REG_CFG2: nxt_resp = {cfg2_ff & CFG2_MASK, 8'h00};
			default: nxt_resp = 16'h0000;
		endcase
	end

	// Register file; bus stays live in every power state
	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			ptr_ff <= PTR_RST;
			cfg_ff <= CFG_RST;
			cfg2_ff <= CFG2_RST;
			upper_ff <= UPPER_RST;
			lower_ff <= LOWER_RST;
			byte_idx_ff <= 1'b0;
		end
		else if (new_cmd && hold_ff.op == op_ptr)
		begin
			ptr_ff <= hold_ff.data;
			byte_idx_ff <= 1'b0;
		end
		else if (is_wr)
		begin
			byte_idx_ff <= 1'b1;
			case (ptr_ff)
				REG_CFG: cfg_ff <= hold_ff.data;
				REG_CFG2: cfg2_ff <= hold_ff.data & CFG2_MASK;
				REG_UPPER:
				begin
					if (byte_idx_ff)
						upper_ff[0] <= hold_ff.data[7];
					else
						upper_ff <= {hold_ff.data, 1'b0};
				end
				REG_LOWER:
				begin
					if (byte_idx_ff)
						lower_ff[0] <= hold_ff.data[7];
					else
						lower_ff <= {hold_ff.data, 1'b0};
				end
				default: byte_idx_ff <= 1'b1;
			endcase
		end
		else if (end_evt)
		begin
			byte_idx_ff <= 1'b0;
		end
	end

	// Per-transaction flags, dropped at stop or repeated start
	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			had_read_ff <= 1'b0;
			had_temp_rd_ff <= 1'b0;
			wake_pend_ff <= 1'b0;
		end
		else if (end_evt)
		begin
			had_read_ff <= 1'b0;
			had_temp_rd_ff <= 1'b0;
			wake_pend_ff <= 1'b0;
		end
		else
		begin
			if (is_rd)
				had_read_ff <= 1'b1;
			if (is_rd && ptr_ff == REG_TEMP)
				had_temp_rd_ff <= 1'b1;
			// Only a write that finds the part already down wakes it
			if (is_wr && cfg_ff[CFG_SHUTDOWN_BIT])
				wake_pend_ff <= 1'b1;
		end
	end

	// Conversion scheduler
	assign conv_done = (state_ff == sch_conv) && (conv_cnt_ff == CONV_W'(CONV_CYC - 1))
		&& !restart_req && !(off_req && !oneshot_ff);

	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			state_ff <= sch_idle;
			conv_cnt_ff <= '0;
			period_cnt_ff <= '0;
			oneshot_ff <= 1'b0;
			temp_ff <= TEMP_RST;
		end
		else
		begin
			case (state_ff)
				sch_idle:
				begin
					if (off_req)
						state_ff <= sch_off;
					else if (restart_req || period_cnt_ff == PERIOD_W'(PERIOD_CYCLES - 1))
					begin
						state_ff <= sch_conv;
						conv_cnt_ff <= '0;
						period_cnt_ff <= '0;
					end
					else
						period_cnt_ff <= period_cnt_ff + 1'b1;
				end
				sch_conv:
				begin
					period_cnt_ff <= period_cnt_ff + 1'b1;
					if (off_req && !oneshot_ff)
						state_ff <= sch_off;
					else if (restart_req)
					begin
						conv_cnt_ff <= '0;
						period_cnt_ff <= '0;
					end
					else if (conv_done)
					begin
						temp_ff <= i_conv_code;
						state_ff <= off_req ? sch_off : sch_idle;
						oneshot_ff <= 1'b0;
					end
					else
						conv_cnt_ff <= conv_cnt_ff + 1'b1;
				end
				sch_off:
				begin
					if (wake_req || !off_req)
					begin
						state_ff <= sch_conv;
						oneshot_ff <= wake_req;
						conv_cnt_ff <= '0;
						period_cnt_ff <= '0;
					end
				end
				default: state_ff <= sch_idle;
			endcase
		end
	end

	assign o_conv_run = (state_ff == sch_conv);
	assign o_conv_powered = (state_ff != sch_off);

	// Alarm decision at the end of each conversion
	assign hi_fault = $signed(i_conv_code[9:1]) > $signed(upper_ff);
	assign lo_fault = $signed(i_conv_code[9:1]) < $signed(lower_ff);
	assign watch_low = cfg_ff[CFG_LATCHED_BIT] ? arm_low_ff : alarm_ff;
	assign relevant = watch_low ? lo_fault : hi_fault;
	assign fault_inc = fault_cnt_ff + 3'h1;
	assign trip = conv_done && relevant
		&& (fault_inc >= fault_need(cfg_ff[CFG_FAULT_HIGH_BIT:CFG_FAULT_LOW_BIT]));

	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			alarm_ff <= 1'b0;
			arm_low_ff <= 1'b0;
			fault_cnt_ff <= 3'h0;
		end
		else if (sd_clear)
		begin
			// Shutdown wins even over a trip in the same cycle
			alarm_ff <= 1'b0;
			arm_low_ff <= 1'b0;
			fault_cnt_ff <= 3'h0;
		end
		else
		begin
			if (latched_clear)
				alarm_ff <= 1'b0;
			if (trip)
			begin
				// Later assignment lets a trip beat a clearing read
				alarm_ff <= cfg_ff[CFG_LATCHED_BIT] ? 1'b1 : !alarm_ff;
				arm_low_ff <= !watch_low;
				fault_cnt_ff <= 3'h0;
			end
			else if (conv_done)
				fault_cnt_ff <= relevant ? fault_inc : 3'h0;
		end
	end

	// Open drain: output level stays low, only the enable moves
	assign o_alarm_out = 1'b0;
	assign o_alarm_oe_n = oe_n_ff;

	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
			oe_n_ff <= 1'b1;
		else
			oe_n_ff <= !(cfg_ff[CFG_POLARITY_BIT] ? !alarm_ff : alarm_ff);
	end

	always_ff @(posedge i_clock or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			line_s1_ff <= 1'b1;
			line_s2_ff <= 1'b1;
		end
		else
		begin
			line_s1_ff <= i_alarm_in;
			line_s2_ff <= line_s1_ff;
		end
	end

	assign o_alarm_line_low = !line_s2_ff;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!rst_n_ff);

	// Pin level is built from last cycle's config, so compare against that
	a_pin_polarity: assert property (alarm_ff |=>
		(o_alarm_oe_n == $past(cfg_ff[CFG_POLARITY_BIT])))
		else $error("alarm pin level disagrees with polarity");
	a_pin_open_drain: assert property ((!alarm_ff && !cfg_ff[CFG_POLARITY_BIT]) |=>
		o_alarm_oe_n && (o_alarm_out == 1'b0))
		else $error("inactive low-true alarm still sinks the wire");
	a_latched_read_clear: assert property ((latched_clear && !trip && !sd_clear) |=>
		!alarm_ff)
		else $error("finished read did not clear latched alarm");
	a_shutdown_clear: assert property (sd_clear |=> !alarm_ff ##1
		(o_alarm_oe_n == !$past(cfg_ff[CFG_POLARITY_BIT])))
		else $error("shutdown write left alarm active");
	a_fault_reset: assert property ((conv_done && !relevant && !sd_clear && !latched_clear) |=>
		(fault_cnt_ff == 3'h0) && $stable(alarm_ff))
		else $error("non-fault reading did not reset counter");
	a_period_start: assert property ((state_ff == sch_idle && !off_req
		&& period_cnt_ff == PERIOD_W'(PERIOD_CYCLES - 1)) |=> (state_ff == sch_conv))
		else $error("periodic conversion not started");
	a_conv_length: assert property ((state_ff == sch_conv
		&& conv_cnt_ff == CONV_W'(CONV_CYC - 1)
		&& !restart_req && !off_req) |=> (state_ff == sch_idle))
		else $error("conversion window length wrong");
	a_read_restart: assert property (restart_req |=> (state_ff == sch_conv)
		&& (conv_cnt_ff == '0) && (period_cnt_ff == '0) ##1 (period_cnt_ff == PERIOD_W'(1)))
		else $error("restart did not rebase timers");
	a_wake_once: assert property ((wake_req && off_req) |=>
		(state_ff == sch_conv) && oneshot_ff)
		else $error("write in shutdown did not wake");

	c_latched_trip: cover property (cfg_ff[CFG_LATCHED_BIT] && trip);
	c_read_abort: cover property (restart_req && state_ff == sch_conv);
	c_wake: cover property (wake_req);
	c_queue_four: cover property (trip && fault_inc == FAULT_N2);
endmodule // otc_alarm_sched
`default_nettype wire

// >>> verification/otc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module otc_host_model (
	input wire logic i_link_clock,
	input wire logic i_bus_ready,
	input wire otc_pkg::otc_resp_type i_bus_resp,
	output otc_pkg::otc_cmd_type o_bus_cmd,
	output logic o_stuck
);
	import otc_pkg::*;
	initial
	begin
		o_bus_cmd = '0;
		o_stuck = 1'b0;
	end
	// Only one command in flight, never queued
	task automatic xfer(input otc_op_type op, input logic [7:0] d, output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge i_link_clock);
		o_bus_cmd <= '{1'b1, op, d};
		do
		begin
			@(posedge i_link_clock);
			n++;
		end while (i_bus_ready !== 1'b1 && n < 50);
		// Released data flips so a stale copy is never mistaken
		o_bus_cmd <= '{1'b0, op, ~d};
		do
		begin
			@(posedge i_link_clock);
			n++;
		end while (i_bus_resp.valid !== 1'b1 && n < 100);
		rd = i_bus_resp.data;
		if (n >= 100)
			o_stuck <= 1'b1;
	endtask
	task automatic rd_reg(input logic [7:0] p, output logic [15:0] w);
		logic [15:0] x;
		xfer(op_ptr, p, x);
		xfer(op_rd, 8'h00, w);
		xfer(op_end, 8'h00, x);
	endtask
	// A write also wakes a device in shutdown
	task automatic wr_reg(input logic [7:0] p, input logic [7:0] v);
		logic [15:0] x;
		xfer(op_ptr, p, x);
		xfer(op_wr, v, x);
		xfer(op_end, 8'h00, x);
	endtask
endmodule // otc_host_model
`default_nettype wire

// >>> verification/overtemp_alarm_and_conversion_sched_tb.sv
`timescale 1ns/10ps
`default_nettype none
module overtemp_alarm_and_conversion_sched_tb;
	import otc_pkg::*;
	// Just above one conversion, keeps the run short
	localparam int PER = 4050;
	localparam logic [9:0] HOT = 10'h150;
	localparam logic [9:0] MID = 10'h13C;
	localparam logic [9:0] COLD = 10'h100;
	logic clk;
	logic lclk;
	logic rst_n;
	logic [9:0] code;
	otc_cmd_type cmd;
	logic ready;
	otc_resp_type resp;
	logic run;
	logic pwr;
	logic a_out;
	logic oe_n;
	logic low;
	logic stuck;
	logic [15:0] w;
	int errors;
	int checks;
	int n;
	int lim;
	wire logic alarm_wire;
	// Pull-up on the shared wire
	assign alarm_wire = oe_n ? 1'b1 : a_out;
	otc_alarm_sched #(.PERIOD_CYCLES(PER)) dut (
		.i_clock(clk),
		.i_resetn(rst_n),
		.i_link_clock(lclk),
		.i_bus_cmd(cmd),
		.o_bus_ready(ready),
		.o_bus_resp(resp),
		.i_conv_code(code),
		.o_conv_run(run),
		.o_conv_powered(pwr),
		.i_alarm_in(alarm_wire),
		.o_alarm_out(a_out),
		.o_alarm_oe_n(oe_n),
		.o_alarm_line_low(low)
	);
	otc_host_model host (
		.i_link_clock(lclk),
		.i_bus_ready(ready),
		.i_bus_resp(resp),
		.o_bus_cmd(cmd),
		.o_stuck(stuck)
	);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		lclk = 1'b0;
		#3.7;
		forever #16 lclk = ~lclk;
	end
	task automatic print_verdict;
		if (errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask
	always @(posedge stuck)
	begin
		errors++;
		print_verdict();
	end
	task automatic until_run(input logic v, output int k);
		k = 0;
		while (run !== v)
		begin
			@(negedge clk);
			k++;
			if (k > 9000)
			begin
				errors++;
				print_verdict();
			end
		end
	endtask
	// Sync lag of the wire is 2-3 cycles
	task automatic settle(input logic e);
		repeat (8) @(negedge clk);
		chk("alarm_line_low", 16'(low), 16'(e));
		chk("alarm_oe_n", 16'(oe_n), 16'(!e));
	endtask
	task automatic conv(input logic [9:0] c, input logic e);
		@(posedge clk);
		code <= c;
		until_run(1'b1, n);
		until_run(1'b0, n);
		settle(e);
	endtask
	initial
	begin
		rst_n = 1'b0;
		code = MID;
		errors = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge lclk);
		host.xfer(op_rd, 8'h00, w);
		chk("temp_default", w, 16'h0000);
		host.xfer(op_end, 8'h00, w);
		repeat (4) @(negedge clk);
		chk("start_on_read", 16'(run), 16'h0001);
		host.rd_reg(REG_CFG, w);
		chk("cfg_default", w, 16'h0000);
		host.rd_reg(REG_LOWER, w);
		chk("lower_default", w, 16'h4B00);
		host.rd_reg(REG_UPPER, w);
		chk("upper_default", w, 16'h5000);
		chk("alarm_out", 16'(a_out), 16'h0000);
		until_run(1'b0, n);
		@(posedge clk);
		code <= HOT;
		until_run(1'b1, n);
		chk("idle_cycles", n[15:0], 16'(PER - CONV_CYC));
		until_run(1'b0, n);
		chk("conv_cycles", n[15:0], 16'(CONV_CYC));
		settle(1'b1);
		@(posedge clk);
		code <= COLD;
		until_run(1'b1, n);
		repeat (2000) @(negedge clk);
		host.rd_reg(REG_TEMP, w);
		chk("temp_prev", w, {HOT, 6'h00});
		until_run(1'b0, n);
		chk("restarted", 16'(n > CONV_CYC - 80 && n < CONV_CYC), 16'h0001);
		@(posedge clk);
		code <= MID;
		until_run(1'b1, n);
		chk("rebased_idle", n[15:0], 16'(PER - CONV_CYC));
		settle(1'b0);
		host.wr_reg(REG_CFG, 8'h04);
		settle(1'b1);
		host.wr_reg(REG_CFG, 8'h02);
		conv(HOT, 1'b1);
		conv(MID, 1'b1);
		host.rd_reg(REG_CFG, w);
		chk("cfg_rw", w, 16'h0200);
		settle(1'b0);
		conv(HOT, 1'b0);
		conv(COLD, 1'b1);
		host.rd_reg(REG_LOWER, w);
		settle(1'b0);
		conv(COLD, 1'b0);
		conv(HOT, 1'b1);
		for (int q = 1; q < 4; q++)
		begin
			host.wr_reg(REG_CFG, 8'h03);
			settle(1'b0);
			chk("powered", 16'(pwr), 16'h0000);
			host.wr_reg(REG_CFG, {3'h0, q[1:0], 3'h2});
			lim = (q == 3) ? 6 : 2 * q;
			if (q == 1)
			begin
				conv(HOT, 1'b0);
				conv(MID, 1'b0);
			end
			for (int k = 1; k <= lim; k++)
				conv(HOT, k == lim);
		end
		host.wr_reg(REG_CFG, 8'h01);
		n = 0;
		repeat (PER + 100)
		begin
			@(negedge clk);
			if (run !== 1'b0)
				n++;
		end
		chk("stopped", n[15:0], 16'h0000);
		host.rd_reg(REG_TEMP, w);
		chk("temp_kept", w, {HOT, 6'h00});
		@(posedge clk);
		code <= MID;
		host.wr_reg(REG_CFG, 8'h01);
		until_run(1'b1, n);
		until_run(1'b0, n);
		repeat (8) @(negedge clk);
		chk("back_off", 16'(pwr), 16'h0000);
		host.rd_reg(REG_TEMP, w);
		chk("temp_new", w, {MID, 6'h00});
		host.rd_reg(8'h04, w);
		chk("unmapped", w, 16'h0000);
		host.xfer(op_ptr, REG_UPPER, w);
		host.xfer(op_wr, 8'h50, w);
		host.xfer(op_wr, 8'h80, w);
		host.xfer(op_end, 8'h00, w);
		host.rd_reg(REG_UPPER, w);
		chk("upper_rw", w, 16'h5080);
		host.wr_reg(REG_CFG2, 8'hFF);
		host.rd_reg(REG_CFG2, w);
		chk("cfg2_rw", w, 16'hC000);
		print_verdict();
	end
endmodule // overtemp_alarm_and_conversion_sched_tb
`default_nettype wire
